// ---- common/fdc_cmd_pkg.sv ----
package fdc_cmd_pkg;
   // command opcodes, upper nibble of the command byte
   localparam logic [3:0] op_abort = 4'hd;
   localparam logic [3:0] op_format = 4'hf;
   // abort condition bit positions in the command byte
   localparam int cond_to_ready = 0;
   localparam int cond_to_not_ready = 1;
   localparam int cond_index = 2;
   localparam int cond_immediate = 3;
   // status bit positions
   localparam int status_bit_low = 0;
   localparam int st_byte_req = 1;
   localparam int st_lost = 2;
   localparam int st_not_ready = 7;
   localparam int status_bit_top = 7;
   localparam logic [7:0] status_reset = 8'h00;
   // format control byte codes, written mark bytes, clock patterns, crc and fifo constants
   localparam logic [7:0] fb_mark_lo = 8'hf5;
   localparam logic [7:0] fb_mark_hi = 8'hfe;
   localparam logic [7:0] fb_a1_preset = 8'hf5;
   localparam logic [7:0] fb_c2 = 8'hf6;
   localparam logic [7:0] fb_crc = 8'hf7;
   localparam logic [7:0] fb_dam_lo = 8'hf8;
   localparam logic [7:0] fb_index = 8'hfc;
   localparam logic [7:0] fb_idam = 8'hfe;
   localparam logic [7:0] wr_a1 = 8'ha1;
   localparam logic [7:0] wr_c2 = 8'hc2;
   localparam logic [7:0] clk_normal = 8'hff;
   localparam logic [7:0] clk_mark = 8'hc7;
   localparam logic [7:0] clk_index = 8'hd7;
   localparam logic [7:0] clk_none = 8'h00;
   localparam logic [15:0] crc_preset = 16'hffff;
   localparam logic [15:0] crc_poly = 16'h1021;
   localparam int fifo_depth = 8;
   localparam int byte_w = 8;
   // one encoded disk byte handed to the serializer
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] clock; // clock pattern, single density
      logic missing_clk; // double density mark byte
   } disk_byte_s;
endpackage

// ---- logic/disk_ctrl_abort_status_format.sv ----
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
   parameter int width = 8,
   parameter int depth = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [aw:0] cnt_q, cnt_d;
   logic push, pop;

   // pointer and count update; full and empty come straight from the count
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_d = push ? aw'(wp_q + 1'b1) : wp_q;
      rp_d = pop ? aw'(rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = (aw+1)'(cnt_q + 1'b1);
      else if (pop && !push)
         cnt_d = (aw+1)'(cnt_q - 1'b1);
      in_ready = cnt_q != (aw+1)'(depth);
      out_valid = cnt_q != '0;
      out_data = mem[rp_q];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // storage has no reset; empty flag keeps stale words unseen
   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wp_q] <= in_data;
   end
endmodule // byte_fifo

module disk_ctrl_abort_status_format (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmd_we,
   input wire logic data_we,
   input wire logic status_re,
   input wire logic [7:0] wr_data,
   output logic [7:0] controller_status,
   output logic interrupt_request,
   output logic byte_request,
   input wire logic double_density,
   input wire logic drive_ready,
   input wire logic index_pulse,
   input wire logic other_done,
   input wire logic [7:0] other_status,
   input wire logic byte_slot,
   output logic disk_valid,
   input wire logic disk_ready,
   output fdc_cmd_pkg::disk_byte_s disk_byte,
   output logic format_active
);
   typedef enum logic [1:0] {st_idle, st_run, st_fmt_wait, st_fmt_write} ctrl_e;
   ctrl_e state_q, state_d;
   logic [7:0] status_q, status_d;
   logic [7:0] byte_holding_register_q, byte_holding_register_d;
   logic fresh_q, fresh_d;
   logic req_q, req_d;
   logic [3:0] cond_q, cond_d;
   logic imm_hold_q, imm_hold_d;
   logic clr_armed_q, clr_armed_d;
   logic irq_q, irq_d;
   logic ready_q, ready_d, index_q, index_d;
   logic crc_pend_q, crc_pend_d;
   logic [15:0] crc_q, crc_d;
   fdc_cmd_pkg::disk_byte_s enc;
   logic enc_valid, enc_ready, out_valid_w;
   fdc_cmd_pkg::disk_byte_s out_w;
   logic is_abort, rise_ready, fall_ready, index_edge, cond_hit, clr_evt;

   // crc step over one byte, msb first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = (r[15] ^ b[i]) ? ((r << 1) ^ fdc_cmd_pkg::crc_poly) : (r << 1);
      return r;
   endfunction

   // encoded bytes go through a small fifo so the serializer can stall the format engine
   byte_fifo #(
      .width($bits(fdc_cmd_pkg::disk_byte_s)),
      .depth(fdc_cmd_pkg::fifo_depth)
   ) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(enc_valid),
      .in_ready(enc_ready),
      .in_data(enc),
      .out_valid(out_valid_w),
      .out_ready(disk_ready),
      .out_data(out_w)
   );

   // format byte encoding and command/status sequencing
   always_comb
   begin
      state_d = state_q;
      status_d = status_q;
      byte_holding_register_d = byte_holding_register_q;
      fresh_d = fresh_q;
      req_d = req_q;
      cond_d = cond_q;
      imm_hold_d = imm_hold_q;
      clr_armed_d = clr_armed_q;
      irq_d = irq_q;
      crc_pend_d = crc_pend_q;
      crc_d = crc_q;
      ready_d = drive_ready;
      index_d = index_pulse;
      enc = '{data: 8'h00, clock: fdc_cmd_pkg::clk_normal, missing_clk: 1'b0};
      enc_valid = 1'b0;
      is_abort = wr_data[7:4] == fdc_cmd_pkg::op_abort;
      rise_ready = drive_ready && !ready_q;
      fall_ready = !drive_ready && ready_q;
      index_edge = index_pulse && !index_q;
      cond_hit = (cond_q[fdc_cmd_pkg::cond_to_ready] && rise_ready)
         || (cond_q[fdc_cmd_pkg::cond_to_not_ready] && fall_ready)
         || (cond_q[fdc_cmd_pkg::cond_index] && index_edge);
      clr_evt = status_re || cmd_we;
      // clear of a pending interrupt; a new condition in the same cycle wins below
      if (clr_evt && (!imm_hold_q || clr_armed_q))
      begin
         irq_d = 1'b0;
         imm_hold_d = 1'b0;
         clr_armed_d = 1'b0;
      end
      if (cond_hit)
         irq_d = 1'b1;
      // walk the format track: from the index, each byte slot with fifo room writes one held byte, crc byte or zero fill, until the next index
      if ((state_q == st_fmt_wait || state_q == st_fmt_write) && byte_slot && enc_ready)
      begin
         if (state_q == st_fmt_wait && index_edge && !fresh_q)
         begin
            state_d = st_idle;
            status_d[fdc_cmd_pkg::status_bit_low] = 1'b0;
            status_d[fdc_cmd_pkg::st_lost] = 1'b1;
            irq_d = 1'b1;
         end
         else if (state_q == st_fmt_write && index_edge)
         begin
            state_d = st_idle;
            status_d[fdc_cmd_pkg::status_bit_low] = 1'b0;
            irq_d = 1'b1;
            req_d = 1'b0;
         end
         else if (state_q == st_fmt_write || (fresh_q && index_edge))
         begin
            state_d = st_fmt_write;
            // bytes pass one by one, so any sector length the host lays out is written
            enc_valid = 1'b1;
            req_d = 1'b1;
            fresh_d = 1'b0;
            if (crc_pend_q)
            begin
               enc.data = crc_q[7:0]; // second crc byte
               crc_pend_d = 1'b0;
            end
            else if (!fresh_q)
            begin
               enc.data = 8'h00;
               status_d[fdc_cmd_pkg::st_lost] = 1'b1;
               crc_d = crc_byte(crc_q, 8'h00);
            end
            else if (byte_holding_register_q == fdc_cmd_pkg::fb_crc)
            begin
               enc.data = crc_q[15:8];
               crc_pend_d = 1'b1;
               fresh_d = 1'b1; // hold one slot for the low crc byte
               req_d = 1'b0;
            end
            else if (double_density)
            begin
               enc.data = byte_holding_register_q;
               crc_d = crc_byte(crc_q, byte_holding_register_q);
               if (byte_holding_register_q == fdc_cmd_pkg::fb_a1_preset)
               begin
                  enc.data = fdc_cmd_pkg::wr_a1;
                  enc.missing_clk = 1'b1;
                  crc_d = crc_byte(fdc_cmd_pkg::crc_preset, fdc_cmd_pkg::wr_a1);
               end
               else if (byte_holding_register_q == fdc_cmd_pkg::fb_c2)
               begin
                  enc.data = fdc_cmd_pkg::wr_c2;
                  enc.missing_clk = 1'b1;
               end
            end
            else
            begin
               enc.data = byte_holding_register_q;
               crc_d = crc_byte(crc_q, byte_holding_register_q);
               if (byte_holding_register_q >= fdc_cmd_pkg::fb_dam_lo
                  && byte_holding_register_q != fdc_cmd_pkg::fb_index
                  && byte_holding_register_q != 8'hfd && byte_holding_register_q != 8'hff)
               begin
                  enc.clock = fdc_cmd_pkg::clk_mark;
                  crc_d = crc_byte(fdc_cmd_pkg::crc_preset, byte_holding_register_q);
               end
               else if (byte_holding_register_q == fdc_cmd_pkg::fb_index)
                  enc.clock = fdc_cmd_pkg::clk_index;
            end
         end
      end
      if (state_q == st_run && other_done)
      begin
         state_d = st_idle;
         status_d = other_status;
         status_d[fdc_cmd_pkg::status_bit_low] = 1'b0;
         irq_d = 1'b1;
      end
      // a host write in the slot cycle wins, so its byte waits for the next slot
      if (data_we)
      begin
         byte_holding_register_d = wr_data;
         fresh_d = 1'b1;
         req_d = 1'b0;
      end
      // command write is taken in any state
      if (cmd_we)
      begin
         if (is_abort)
         begin
            cond_d = wr_data[3:0];
            state_d = st_idle;
            req_d = 1'b0;
            crc_pend_d = 1'b0;
            if (state_q == st_idle)
            begin
               status_d = fdc_cmd_pkg::status_reset;
               status_d[fdc_cmd_pkg::st_not_ready] = !drive_ready;
            end
            status_d[fdc_cmd_pkg::status_bit_low] = 1'b0;
            if (wr_data[fdc_cmd_pkg::cond_immediate])
            begin
               irq_d = 1'b1;
               imm_hold_d = 1'b1;
               clr_armed_d = 1'b1;
            end
         end
         else
         begin
            cond_d = '0;
            status_d = fdc_cmd_pkg::status_reset;
            status_d[fdc_cmd_pkg::status_bit_low] = 1'b1;
            irq_d = 1'b0;
            fresh_d = 1'b0;
            if (wr_data[7:4] == fdc_cmd_pkg::op_format)
            begin
               state_d = st_fmt_wait;
               req_d = 1'b1;
            end
            else
               state_d = st_run;
         end
      end
      status_d[fdc_cmd_pkg::st_byte_req] = req_d;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= st_idle;
         status_q <= fdc_cmd_pkg::status_reset;
         byte_holding_register_q <= 8'h00;
         fresh_q <= 1'b0;
         req_q <= 1'b0;
         cond_q <= 4'h0;
         imm_hold_q <= 1'b0;
         clr_armed_q <= 1'b0;
         irq_q <= 1'b0;
         ready_q <= 1'b0;
         index_q <= 1'b0;
         crc_pend_q <= 1'b0;
         crc_q <= fdc_cmd_pkg::crc_preset;
      end
      else
      begin
         state_q <= state_d;
         status_q <= status_d;
         byte_holding_register_q <= byte_holding_register_d;
         fresh_q <= fresh_d;
         req_q <= req_d;
         cond_q <= cond_d;
         imm_hold_q <= imm_hold_d;
         clr_armed_q <= clr_armed_d;
         irq_q <= irq_d;
         ready_q <= ready_d;
         index_q <= index_d;
         crc_pend_q <= crc_pend_d;
         crc_q <= crc_d;
      end
   end

   // outputs from flip-flops or the fifo, except format_active, which is decoded from state_q
   assign controller_status = status_q;
   assign interrupt_request = irq_q;
   assign byte_request = req_q;
   assign disk_valid = out_valid_w;
   assign disk_byte = out_w;
   assign format_active = state_q == st_fmt_write;
endmodule // disk_ctrl_abort_status_format

`default_nettype wire

// ---- tb/disk_ctrl_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module disk_ctrl_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmd_we,
   input wire logic data_we,
   input wire logic status_re,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] controller_status,
   input wire logic interrupt_request,
   input wire logic byte_request,
   input wire logic byte_slot,
   input wire logic index_pulse
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic abort_w;
   // abort opcode seen on a command write
   assign abort_w = cmd_we && wr_data[7:4] == fdc_cmd_pkg::op_abort;
   property p_busy_set;
      cmd_we && !abort_w |=> controller_status[0];
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set");
   property p_abort_busy;
      abort_w |=> !controller_status[0];
   endproperty
   a_abort_busy: assert property (p_abort_busy) else $error("busy kept");
   property p_abort_keep;
      abort_w && controller_status[0] |=> $stable(controller_status[6:2]);
   endproperty
   a_abort_keep: assert property (p_abort_keep) else $error("status moved");
   property p_immediate;
      abort_w && wr_data[fdc_cmd_pkg::cond_immediate] |=> interrupt_request [*2];
   endproperty
   a_immediate: assert property (p_immediate) else $error("no immediate irq");
   property p_silent;
      abort_w && wr_data[3:0] == 4'h0 && !interrupt_request |=> !interrupt_request [*3];
   endproperty
   a_silent: assert property (p_silent) else $error("irq on empty abort");
   // a read only clears when no new event competes in the same cycle
   property p_read_clear;
      interrupt_request && status_re && !cmd_we && !index_pulse |=> !interrupt_request;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("irq not cleared");
   property p_fmt_req;
      cmd_we && wr_data[7:4] == fdc_cmd_pkg::op_format |=> byte_request && controller_status[0];
   endproperty
   a_fmt_req: assert property (p_fmt_req) else $error("no first request");
   property p_req_clear;
      byte_request && data_we && !byte_slot |=> !byte_request;
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request kept");
   property p_req_bit;
      controller_status[0] && byte_request |-> controller_status[fdc_cmd_pkg::st_byte_req];
   endproperty
   a_req_bit: assert property (p_req_bit) else $error("status bit wrong");
endmodule // disk_ctrl_monitor
bind disk_ctrl_abort_status_format disk_ctrl_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
   .cmd_we(cmd_we), .data_we(data_we), .status_re(status_re), .wr_data(wr_data),
   .controller_status(controller_status), .interrupt_request(interrupt_request),
   .byte_request(byte_request), .byte_slot(byte_slot), .index_pulse(index_pulse));
`default_nettype wire

// ---- tb/disk_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module disk_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic stall,
   input wire logic disk_valid,
   input wire fdc_cmd_pkg::disk_byte_s disk_byte,
   output logic byte_slot,
   output logic disk_ready,
   output logic index_pulse
);
   logic [4:0] cnt_q;
   fdc_cmd_pkg::disk_byte_s got[$];
   // one byte time per 32 cycles, grid restarts at an index so writing starts on it
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
         cnt_q <= 5'h01;
         index_pulse <= 1'b0;
      end
      else
      begin
         cnt_q <= fire ? 5'h00 : cnt_q + 5'h01;
         index_pulse <= fire | (index_pulse & cnt_q != 5'h03);
      end
   assign byte_slot = cnt_q == 5'h00;
   // a stalled serializer holds the fifo back
   assign disk_ready = !stall;
   // record every byte that reaches the disk
   always @(posedge mclk)
      if (disk_valid && disk_ready)
         got.push_back(disk_byte);
endmodule // disk_model
`default_nettype wire

// ---- tb/disk_ctrl_abort_status_format_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module disk_ctrl_abort_status_format_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_we = 1'b0, data_we = 1'b0, status_re = 1'b0, other_done = 1'b0;
   logic dd = 1'b0, drive_ready = 1'b1, fire = 1'b0, stall = 1'b0;
   logic [7:0] wr_data = 8'h00, other_status = 8'h00;
   logic [7:0] controller_status;
   logic interrupt_request, byte_request, disk_valid, format_active;
   logic byte_slot, disk_ready, index_pulse;
   fdc_cmd_pkg::disk_byte_s disk_byte;
   logic [7:0] seq [6] = '{8'hff, 8'h00, 8'hfc, 8'hfe, 8'h01, 8'hf7};
   logic [7:0] dd_in [6] = '{8'h4e, 8'hf6, 8'hf5, 8'hf5, 8'hf5, 8'hfe};
   logic [7:0] dd_exp [7] = '{8'h4e, 8'hc2, 8'ha1, 8'ha1, 8'ha1, 8'hfe, 8'h00};
   logic [15:0] crc_exp;
   fdc_cmd_pkg::disk_byte_s gb;
   logic [7:0] clk_exp [5] = '{8'hff, 8'hff, 8'hd7, 8'hc7, 8'hff};
   int err_count = 0;
   int total_checks = 0;
   always #2.5 mclk = ~mclk;
   disk_ctrl_abort_status_format i_dut (.mclk(mclk), .rst_n(rst_n), .cmd_we(cmd_we),
      .data_we(data_we), .status_re(status_re), .wr_data(wr_data),
      .controller_status(controller_status), .interrupt_request(interrupt_request),
      .byte_request(byte_request), .double_density(dd), .drive_ready(drive_ready),
      .index_pulse(index_pulse), .other_done(other_done), .other_status(other_status),
      .byte_slot(byte_slot), .disk_valid(disk_valid), .disk_ready(disk_ready),
      .disk_byte(disk_byte), .format_active(format_active));
   disk_model i_disk (.mclk(mclk), .rst_n(rst_n), .fire(fire), .stall(stall),
      .disk_valid(disk_valid), .disk_byte(disk_byte), .byte_slot(byte_slot),
      .disk_ready(disk_ready), .index_pulse(index_pulse));
   // one register access: 0 command write, 1 byte write, 2 status read
   task automatic put(input int k, input logic [7:0] b);
      @(posedge mclk);
      wr_data <= b;
      cmd_we <= k == 0;
      data_we <= k == 1;
      status_re <= k == 2;
      @(posedge mclk);
      cmd_we <= 1'b0;
      data_we <= 1'b0;
      status_re <= 1'b0;
      #1;
   endtask
   // bounded wait: 0 interrupt, 1 byte request, 2 byte slot
   task automatic wait_hi(input int sel);
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (n < 300 && (sel == 0 ? interrupt_request : sel == 1 ? byte_request : byte_slot) !== 1'b1);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // reference crc, one bit at a time from the top
   function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? fdc_cmd_pkg::crc_poly : 16'h0000);
      return c;
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard, far beyond the roughly one thousand cycles the tests need
   initial
   begin
      #100000;
      err_count++;
      wrap_up;
   end
   // main sequence
   initial
   begin
      crc_exp = crc_ref(crc_ref(fdc_cmd_pkg::crc_preset, seq[3]), seq[4]);
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      tick(2);
      `CHK(controller_status, fdc_cmd_pkg::status_reset)
      put(0, 8'h10);
      `CHK(controller_status, 8'h01)
      @(posedge mclk);
      other_status <= 8'h04;
      other_done <= 1'b1;
      @(posedge mclk);
      other_done <= 1'b0;
      tick(2);
      `CHK({interrupt_request, controller_status}, {1'b1, 8'h04})
      put(2, 8'h00);
      put(0, 8'h10);
      `CHK({interrupt_request, controller_status}, {1'b0, 8'h01})
      put(0, 8'hd0);
      `CHK(controller_status, 8'h00)
      tick(4);
      `CHK(interrupt_request, 1'b0)
      @(posedge mclk);
      drive_ready <= 1'b0;
      put(0, 8'hd0);
      `CHK({controller_status[7], controller_status[0]}, 2'b10)
      $display("test abort_status done");
      // to-ready, to-not-ready, index conditions in turn
      for (int i = 0; i < 3; i++)
      begin
         put(0, 8'hd0 | (8'h01 << i));
         tick(3);
         `CHK(interrupt_request, 1'b0)
         @(posedge mclk);
         drive_ready <= i == 0 ? 1'b1 : 1'b0;
         fire <= i == 2;
         @(posedge mclk);
         fire <= 1'b0;
         wait_hi(0);
         `CHK(interrupt_request, 1'b1)
         tick(6);
         `CHK(interrupt_request, 1'b1)
         put(2, 8'h00);
         `CHK(interrupt_request, 1'b0)
      end
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      wait_hi(0);
      `CHK(interrupt_request, 1'b1)
      tick(6);
      put(2, 8'h00);
      put(0, 8'hd8);
      `CHK(interrupt_request, 1'b1)
      tick(5);
      `CHK(interrupt_request, 1'b1)
      put(2, 8'h00);
      `CHK(interrupt_request, 1'b0)
      // a second immediate interrupt is dropped by a reset in mid-run
      put(0, 8'hd8);
      tick(3);
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      tick(2);
      `CHK({interrupt_request, controller_status}, 9'h000)
      @(posedge mclk);
      drive_ready <= 1'b1;
      $display("test conditions done");
      // format: one byte per request, marks and crc, then zero fill under stall
      put(0, 8'hf0);
      `CHK({byte_request, controller_status[0]}, 2'b11)
      put(1, seq[0]);
      `CHK(byte_request, 1'b0)
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      for (int i = 1; i < 6; i++)
      begin
         wait_hi(1);
         put(1, seq[i]);
      end
      // stall before the first underrun slot so the zero fill piles up in the fifo
      wait_hi(1);
      tick(3);
      @(posedge mclk);
      stall <= 1'b1;
      `CHK(i_disk.got.size(), 7)
      `CHK({i_disk.got[5].data, i_disk.got[6].data}, crc_exp)
      for (int i = 0; i < 5; i++)
         `CHK({i_disk.got[i].data, i_disk.got[i].clock}, {seq[i], clk_exp[i]})
      repeat (12) wait_hi(2);
      `CHK(i_disk.got.size(), 7)
      `CHK(disk_valid, 1'b1)
      wait_hi(2);
      @(posedge mclk);
      stall <= 1'b0;
      tick(12);
      `CHK(i_disk.got.size(), 7 + fdc_cmd_pkg::fifo_depth)
      `CHK({i_disk.got[7].data, i_disk.got[7].clock}, {8'h00, fdc_cmd_pkg::clk_normal})
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      wait_hi(0);
      `CHK({interrupt_request, controller_status[2:0]}, 4'b1100)
      put(2, 8'h00);
      $display("test format done");
      // double density: marks lose a clock; an abort after an underrun ends the run
      @(posedge mclk);
      dd <= 1'b1;
      put(0, 8'hf0);
      put(1, dd_in[0]);
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      for (int i = 1; i < 6; i++)
      begin
         wait_hi(1);
         put(1, dd_in[i]);
      end
      wait_hi(1);
      wait_hi(2);
      put(0, 8'hd0);
      `CHK(controller_status, 8'h04)
      `CHK(i_disk.got.size(), 22)
      for (int i = 0; i < 7; i++)
      begin
         gb = i_disk.got[15 + i];
         `CHK({gb.data, gb.missing_clk}, {dd_exp[i], i > 0 && i < 5})
      end
      $display("test double_density done");
      wrap_up;
   end
endmodule // disk_ctrl_abort_status_format_tb
`default_nettype wire
